// [core/light_result_fifo_threshold_regs.v]
`timescale 1ns/100ps
`include "light_hist_consts.vh"
module light_result_fifo_threshold_regs (
  input wire ref_clk,
  input wire arst_n,
  input wire conv_done,
  input wire [3:0] conv_scale,
  input wire [11:0] conv_mant_high,
  input wire [7:0] conv_mant_low,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  output wire reg_hit,
  output wire [3:0] live_scale,
  output wire [11:0] live_mant_high,
  output wire [7:0] live_mant_low,
  output wire [3:0] live_sample_count,
  output wire [3:0] live_check_bits,
  output wire [19:0] live_mant,
  output wire [3:0] low_limit_scale,
  output wire [19:0] low_limit_mant,
  output wire [3:0] high_limit_scale,
  output wire [19:0] high_limit_mant
);

  // ----------------------------------------
  // live result and history stages
  // ----------------------------------------
  reg [3:0] live_scale_q;
  reg [11:0] live_mant_high_q;
  reg [7:0] live_mant_low_q;
  reg [3:0] live_count_q;
  reg [3:0] live_check_q;
  reg [3:0] hist0_scale;
  reg [11:0] hist0_mant_high;
  reg [7:0] hist0_mant_low;
  reg [3:0] hist0_sample_count;
  reg [3:0] hist0_check_bits;
  reg [3:0] hist1_scale;
  reg [11:0] hist1_mant_high;
  reg [7:0] hist1_mant_low;
  reg [3:0] hist1_sample_count;
  reg [3:0] hist1_check_bits;
  reg [3:0] hist2_scale;
  reg [11:0] hist2_mant_high;
  reg [7:0] hist2_mant_low;
  reg [3:0] hist2_sample_count;
  reg [3:0] hist2_check_bits;
  reg [15:0] low_limit_word;
  reg [15:0] high_limit_word;
  wire [3:0] next_count;
  wire [3:0] next_check;

  assign next_count = live_count_q + `CNT_STEP;

  check_bits_calc u_check (
    .scale(conv_scale),
    .mant_high(conv_mant_high),
    .mant_low(conv_mant_low),
    .count(next_count),
    .check(next_check)
  );

  // stage zero keeps the live value being replaced, so it lags one conversion
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      live_scale_q <= 4'h0;
      live_mant_high_q <= 12'h000;
      live_mant_low_q <= 8'h00;
      live_count_q <= `CNT_RESET;
      live_check_q <= 4'h0;
      hist0_scale <= 4'h0;
      hist0_mant_high <= 12'h000;
      hist0_mant_low <= 8'h00;
      hist0_sample_count <= 4'h0;
      hist0_check_bits <= 4'h0;
      hist1_scale <= 4'h0;
      hist1_mant_high <= 12'h000;
      hist1_mant_low <= 8'h00;
      hist1_sample_count <= 4'h0;
      hist1_check_bits <= 4'h0;
      hist2_scale <= 4'h0;
      hist2_mant_high <= 12'h000;
      hist2_mant_low <= 8'h00;
      hist2_sample_count <= 4'h0;
      hist2_check_bits <= 4'h0;
    end else if (conv_done) begin
      hist2_scale <= hist1_scale;
      hist2_mant_high <= hist1_mant_high;
      hist2_mant_low <= hist1_mant_low;
      hist2_sample_count <= hist1_sample_count;
      hist2_check_bits <= hist1_check_bits;
      hist1_scale <= hist0_scale;
      hist1_mant_high <= hist0_mant_high;
      hist1_mant_low <= hist0_mant_low;
      hist1_sample_count <= hist0_sample_count;
      hist1_check_bits <= hist0_check_bits;
      hist0_scale <= live_scale_q;
      hist0_mant_high <= live_mant_high_q;
      hist0_mant_low <= live_mant_low_q;
      hist0_sample_count <= live_count_q;
      hist0_check_bits <= live_check_q;
      live_scale_q <= conv_scale;
      live_mant_high_q <= conv_mant_high;
      live_mant_low_q <= conv_mant_low;
      live_count_q <= next_count;
      live_check_q <= next_check;
    end
  end

  // ----------------------------------------
  // threshold registers
  // ----------------------------------------
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_limit_word <= `LOW_LIMIT_RESET;
      high_limit_word <= `HIGH_LIMIT_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `OFF_LOW_LIMIT) begin
        low_limit_word <= reg_wdata;
      end
      if (reg_addr == `OFF_HIGH_LIMIT) begin
        high_limit_word <= reg_wdata;
      end
      // history offsets have no write path
    end
  end

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  assign reg_hit = (reg_addr >= `OFF_HIST0_LOW) && (reg_addr <= `OFF_HIGH_LIMIT);

  // unmapped offsets read as zero; data held between reads
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `READ_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFF_HIST0_LOW: reg_rdata <= {hist0_mant_low, hist0_sample_count, hist0_check_bits};
        `OFF_HIST1_HIGH: reg_rdata <= {hist1_scale, hist1_mant_high};
        `OFF_HIST1_LOW: reg_rdata <= {hist1_mant_low, hist1_sample_count, hist1_check_bits};
        `OFF_HIST2_HIGH: reg_rdata <= {hist2_scale, hist2_mant_high};
        `OFF_HIST2_LOW: reg_rdata <= {hist2_mant_low, hist2_sample_count, hist2_check_bits};
        `OFF_LOW_LIMIT: reg_rdata <= low_limit_word;
        `OFF_HIGH_LIMIT: reg_rdata <= high_limit_word;
        default: reg_rdata <= `READ_ZERO;
      endcase
    end
  end

  // ----------------------------------------
  // outputs to comparison logic
  // ----------------------------------------
  assign live_scale = live_scale_q;
  assign live_mant_high = live_mant_high_q;
  assign live_mant_low = live_mant_low_q;
  assign live_sample_count = live_count_q;
  assign live_check_bits = live_check_q;
  assign low_limit_scale = low_limit_word[`SCALE_HI:`SCALE_LO];
  assign high_limit_scale = high_limit_word[`SCALE_HI:`SCALE_LO];

  mant_join u_live_join (
    .mant_high(live_mant_high_q),
    .mant_low(live_mant_low_q),
    .mant(live_mant)
  );

  // thresholds have no low byte; it is zero
  mant_join u_low_join (
    .mant_high(low_limit_word[`MHIGH_HI:`MHIGH_LO]),
    .mant_low(8'h00),
    .mant(low_limit_mant)
  );

  mant_join u_high_join (
    .mant_high(high_limit_word[`MHIGH_HI:`MHIGH_LO]),
    .mant_low(8'h00),
    .mant(high_limit_mant)
  );

endmodule // light_result_fifo_threshold_regs

// [core/light_hist_consts.vh]
`ifndef LIGHT_HIST_CONSTS_VH
`define LIGHT_HIST_CONSTS_VH
// register offsets
`define ADDR_W 8
`define OFF_HIST0_LOW 8'h03
`define OFF_HIST1_HIGH 8'h04
`define OFF_HIST1_LOW 8'h05
`define OFF_HIST2_HIGH 8'h06
`define OFF_HIST2_LOW 8'h07
`define OFF_LOW_LIMIT 8'h08
`define OFF_HIGH_LIMIT 8'h09
// field layout
`define SCALE_HI 15
`define SCALE_LO 12
`define MHIGH_HI 11
`define MHIGH_LO 0
`define MLOW_HI 15
`define MLOW_LO 8
`define CNT_HI 7
`define CNT_LO 4
`define CHK_HI 3
`define CHK_LO 0
`define MANT_SHIFT 8
// reset values and count step
`define HIST_RESET 16'h0000
`define LOW_LIMIT_RESET 16'h0000
`define HIGH_LIMIT_RESET 16'hbfff
`define CNT_STEP 4'h1
`define CNT_RESET 4'h0
`define READ_ZERO 16'h0000
`endif

// [core/check_bits_calc.v]
`timescale 1ns/100ps
// check bits over one result entry
module check_bits_calc (
  input wire [3:0] scale,
  input wire [11:0] mant_high,
  input wire [7:0] mant_low,
  input wire [3:0] count,
  output wire [3:0] check
);
  wire [19:0] m;
  assign m = {mant_high, mant_low};
  assign check[0] = ^{scale, m, count};
  assign check[1] = ^{count[1], count[3], m[1], m[3], m[5], m[7], m[9], m[11], m[13],
                      m[15], m[17], m[19], scale[1], scale[3]};
  assign check[2] = ^{count[3], m[3], m[7], m[11], m[15], m[19], scale[3]};
  assign check[3] = ^{m[3], m[11], m[19]};
endmodule // check_bits_calc

// [core/mant_join.v]
`timescale 1ns/100ps
`include "light_hist_consts.vh"
// joins mantissa halves into twenty bits
module mant_join (
  input wire [11:0] mant_high,
  input wire [7:0] mant_low,
  output wire [19:0] mant
);
  assign mant = ({8'h00, mant_high} << `MANT_SHIFT) + {12'h000, mant_low};
endmodule // mant_join

// [testbench/light_regs_assertions.sv]
`timescale 1ns/100ps
// ------
// port checks
// ------
module light_regs_checker (
  input wire ref_clk,
  input wire arst_n,
  input wire conv_done,
  input wire [11:0] conv_mant_high,
  input wire [7:0] conv_mant_low,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  input wire [11:0] live_mant_high,
  input wire [7:0] live_mant_low,
  input wire [3:0] live_sample_count,
  input wire reg_hit,
  input wire [3:0] low_limit_scale,
  input wire [19:0] live_mant,
  input wire [19:0] low_limit_mant,
  input wire [19:0] high_limit_mant
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  hit_decode_a: assert property (reg_hit == (reg_addr >= 8'h03 && reg_addr <= 8'h09))
    else $error("hit decode");
  low_scale_wr_a: assert property (reg_wr && reg_addr == 8'h08
    |=> low_limit_scale == $past(reg_wdata[15:12])) else $error("low scale write");
  unmapped_read_zero_a: assert property (reg_rd && (reg_addr < 8'h03 || reg_addr > 8'h09)
    |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  rdata_holds_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  live_load_a: assert property (conv_done |=> live_mant_high == $past(conv_mant_high)
    && live_mant_low == $past(conv_mant_low)) else $error("live result not loaded");
  count_step_a: assert property (conv_done
    |=> live_sample_count == $past(live_sample_count) + 4'h1) else $error("count step");
  count_hold_a: assert property (!conv_done |=> $stable(live_sample_count))
    else $error("count moved");
  mant_join_a: assert property (live_mant == {live_mant_high, live_mant_low})
    else $error("mantissa join");
  low_limit_wr_a: assert property (reg_wr && reg_addr == 8'h08
    |=> low_limit_mant == {$past(reg_wdata[11:0]), 8'h00}) else $error("low limit write");
  high_limit_wr_a: assert property (reg_wr && reg_addr == 8'h09
    |=> high_limit_mant == {$past(reg_wdata[11:0]), 8'h00}) else $error("high limit write");
  high_limit_hold_a: assert property (!(reg_wr && reg_addr == 8'h09)
    |=> $stable(high_limit_mant)) else $error("high limit moved");
endmodule // light_regs_checker

bind light_result_fifo_threshold_regs light_regs_checker chk (.*);

// [testbench/reg_host.sv]
`timescale 1ns/100ps
// ------
// host side: strobes change at falling edge
// ------
module reg_host (
  input wire ref_clk,
  input wire [15:0] reg_rdata,
  output reg reg_wr,
  output reg reg_rd,
  output reg [7:0] reg_addr,
  output reg [15:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end
  task wr(input [7:0] a, input [15:0] v);
    begin
      @(negedge ref_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_wdata = ~v;
    end
  endtask
  // data registered one edge after the strobe
  task rd(input [7:0] a, output [15:0] q);
    begin
      @(negedge ref_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      q = reg_rdata;
    end
  endtask
endmodule // reg_host

// [testbench/test_light_result_fifo_threshold_regs.sv]
`timescale 1ns/100ps
module test_light_result_fifo_threshold_regs;
  reg ref_clk, arst_n, conv_done;
  reg [3:0] conv_scale;
  reg [11:0] conv_mant_high;
  reg [7:0] conv_mant_low;
  wire reg_wr, reg_rd, reg_hit;
  wire [7:0] reg_addr, live_mant_low;
  wire [15:0] reg_wdata, reg_rdata;
  wire [3:0] live_scale, live_sample_count, live_check_bits, low_limit_scale, high_limit_scale;
  wire [11:0] live_mant_high;
  wire [19:0] live_mant, low_limit_mant, high_limit_mant;
  integer err_count, comparisons, i;
  reg [15:0] d;
  light_result_fifo_threshold_regs dut (.*);
  reg_host host (.*);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ------
  // expected entry k, count k
  // ------
  function [3:0] crc(input [3:0] e, input [19:0] r, input [3:0] c);
    begin
      crc[0] = ^{e, r, c};
      crc[1] = ^{c[1], c[3], r & 20'haaaaa, e[1], e[3]};
      crc[2] = ^{c[3], r[3], r[7], r[11], r[15], r[19], e[3]};
      crc[3] = ^{r[3], r[11], r[19]};
    end
  endfunction
  function [15:0] hw(input integer k);
    hw = {k[3:0] + 4'h2, 12'h9a5 ^ (12'h111 * k[11:0])};
  endfunction
  function [15:0] lw(input integer k);
    reg [7:0] l;
    reg [15:0] h;
    begin
      l = 8'h3c + 8'h21 * k[7:0];
      h = hw(k);
      lw = {l, k[3:0], crc(h[15:12], {h[11:0], l}, k[3:0])};
    end
  endfunction
  task cmp(input [15:0] g, input [15:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task rdc(input [7:0] a, input [15:0] e);
    begin
      host.rd(a, d);
      cmp(d, e);
    end
  endtask
  task conv(input integer k);
    begin
      @(negedge ref_clk);
      conv_done = 1'b1;
      {conv_scale, conv_mant_high} = hw(k);
      conv_mant_low = lw(k) >> 8;
      @(negedge ref_clk);
      conv_done = 1'b0;
    end
  endtask
  task end_sim;
    begin
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    err_count = 0;
    comparisons = 0;
    conv_done = 1'b0;
    conv_scale = 4'h0;
    conv_mant_high = 12'h000;
    conv_mant_low = 8'h00;
    arst_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    arst_n = 1'b1;
    for (i = 3; i < 9; i = i + 1) rdc(i[7:0], 16'h0000);
    cmp({12'h000, high_limit_scale}, 16'h000b);
    cmp(high_limit_mant[19:4], 16'hfff0);
    rdc(8'h09, 16'hbfff);
    cmp({15'h0000, reg_hit}, 16'h0001);
    rdc(8'h02, 16'h0000);
    rdc(8'h0a, 16'h0000);
    cmp({15'h0000, reg_hit}, 16'h0000);
    host.wr(8'h08, 16'h5a3c);
    rdc(8'h08, 16'h5a3c);
    cmp({12'h000, low_limit_scale}, 16'h0005);
    cmp(low_limit_mant[19:4], 16'ha3c0);
    host.wr(8'h09, 16'h0001);
    rdc(8'h09, 16'h0001);
    cmp({12'h000, high_limit_scale}, 16'h0000);
    for (i = 3; i < 8; i = i + 1) begin
      host.wr(i[7:0], 16'hffff);
      rdc(i[7:0], 16'h0000);
    end
    for (i = 1; i < 5; i = i + 1) conv(i);
    rdc(8'h03, lw(3));
    rdc(8'h04, hw(2));
    rdc(8'h05, lw(2));
    rdc(8'h06, hw(1));
    rdc(8'h07, lw(1));
    d = hw(4);
    cmp({12'h000, live_scale}, {12'h000, d[15:12]});
    cmp(live_mant[15:0], {d[7:0], 8'h00} + {8'h00, live_mant_low});
    d = lw(4);
    cmp({12'h000, live_check_bits}, {12'h000, d[3:0]});
    for (i = 5; i < 21; i = i + 1) conv(i);
    cmp({12'h000, live_sample_count}, 16'h0004);
    rdc(8'h03, lw(19));
    rdc(8'h05, lw(18));
    end_sim;
  end
endmodule // test_light_result_fifo_threshold_regs
